// [pcr_cfg.svh]
// Offsets, field positions, reset values and address constants of the clock config registers
`ifndef PCR_CFG_SVH
`define PCR_CFG_SVH
// Register subaddresses
`define PCR_SUB_LOOP 8'h0A
`define PCR_SUB_DIV_HI 8'h0B
`define PCR_SUB_DIV_LO 8'h0C
`define PCR_SUB_PHA 8'h0D
`define PCR_SUB_PHB 8'h0E
// Field positions inside the data byte
`define PCR_RES_LSB 0
`define PCR_GAIN_LSB 3
`define PCR_DIVHI_LSB 1
`define PCR_PAR_BIT 0
`define PCR_PHASE_LSB 0
`define PCR_CKSRC_BIT 5
`define PCR_CK2EN_BIT 5
`define PCR_STEER_BIT 6
// Reset values
`define PCR_RES_RST 3'h3
`define PCR_GAIN_RST 2'h0
`define PCR_DIV_RST 12'h320
`define PCR_PHASE_RST 5'h00
`define PCR_KOHM_RST 8'h10
`define PCR_MHZV_RST 6'h0F
// Fixed upper bits of the target address byte
`define PCR_I2C_ADDR_HI 5'h13
// Three-wire frame length in bits
`define PCR_TW_BITS 5'h10
`endif

// [pcr_pkg.sv]
// Types shared by the clock config register modules
package pcr_pkg;
	// Target byte phase
	typedef enum logic [2:0] {
		PCR_ST_IDLE = 3'b000,
		PCR_ST_ADDR = 3'b001,
		PCR_ST_SUB = 3'b010,
		PCR_ST_DATA = 3'b011,
		PCR_ST_SKIP = 3'b100
	} pcr_i2c_st_e;
	typedef logic [7:0] pcr_byte_t;
endpackage : pcr_pkg

// [pcr_wr_if.sv]
// Register write carrier between a serial receiver and the register store
`timescale 1ns/1ps
`default_nettype none
interface pcr_wr_if;
	logic wr_stb; // One-cycle write pulse
	logic [7:0] wr_addr; // Register subaddress
	logic [7:0] wr_data; // Register data
	modport src (output wr_stb, output wr_addr, output wr_data);
	modport dst (input wr_stb, input wr_addr, input wr_data);
endinterface : pcr_wr_if
`default_nettype wire

// [pcr_tw_rx.sv]
// Three-wire serial receiver: address byte then data byte, committed at strobe release
`timescale 1ns/1ps
`default_nettype none
`include "pcr_cfg.svh"
module pcr_tw_rx
	import pcr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic sclk_s,
	input wire logic sdata_s,
	input wire logic strobe_n_s,
	pcr_wr_if.src wr
);
	logic sclk_p_q; // Previous serial clock sample
	logic strobe_p_q; // Previous strobe sample
	logic [15:0] shift_q; // Address and data shifter
	logic [4:0] cnt_q; // Bits taken, saturating above a frame
	logic stb_q;
	pcr_byte_t addr_q;
	pcr_byte_t data_q;

	// Edge history of the already synchronised pins
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sclk_p_q <= 1'b0;
			strobe_p_q <= 1'b1;
		end else begin
			sclk_p_q <= sclk_s;
			strobe_p_q <= strobe_n_s;
		end
	end

	// Shift MSB first on rising clock while the strobe is low
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			shift_q <= 16'h0000;
			cnt_q <= 5'h00;
		end else if (strobe_p_q && !strobe_n_s) begin
			cnt_q <= 5'h00; // Strobe taken: new frame
		end else if (!strobe_n_s && sclk_s && !sclk_p_q) begin
			shift_q <= {shift_q[14:0], sdata_s};
			if (cnt_q <= `PCR_TW_BITS) begin
				cnt_q <= cnt_q + 5'h01;
			end
		end
	end

	// Commit on strobe release; a short or long frame is dropped
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stb_q <= 1'b0;
			addr_q <= 8'h00;
			data_q <= 8'h00;
		end else begin
			stb_q <= 1'b0;
			if (!strobe_p_q && strobe_n_s && cnt_q == `PCR_TW_BITS) begin
				stb_q <= 1'b1;
				addr_q <= shift_q[15:8];
				data_q <= shift_q[7:0];
			end
		end
	end

	assign wr.wr_stb = stb_q;
	assign wr.wr_addr = addr_q;
	assign wr.wr_data = data_q;

	property p_tw_commit;
		@(posedge sys_clk) disable iff (reset)
		(!strobe_p_q && strobe_n_s && cnt_q == `PCR_TW_BITS) |=> stb_q && addr_q == $past(shift_q[15:8]);
	endproperty
	a_tw_commit: assert property (p_tw_commit) else $error("three-wire frame not committed");

	property p_tw_no_partial;
		@(posedge sys_clk) disable iff (reset)
		stb_q |-> $past(cnt_q) == `PCR_TW_BITS && $past(!strobe_p_q);
	endproperty
	a_tw_no_partial: assert property (p_tw_no_partial) else $error("partial frame committed");
endmodule : pcr_tw_rx
`default_nettype wire

// [pcr_regs.sv]
// Clock generator config registers with I2C target and three-wire write paths
// Contract
// - Resistance code maps hi-Z,128,32,16,8,4,2,1k
// - Gain code maps 15,20,35,50 MHz/V
// - Defaults: resistance 16k, gain 15 MHz/V
// - Divider twelve bits, default 800
// - Divider LSB encodes even or odd
// - Mode 1 parity change needs two loads
// - Supply reset loads all defaults
// - Power-down leaves register contents intact
// - Source bit: 0 internal, 1 external clock
// - Second clock unused while enable is 0
// - Phase equals code times 11.25 degrees
// - Steering bit picks clock on first pin
// - Source, enable, phases, steering default zero
// - Answer only address 1001 1xx0
// - Address bits two, one from straps
// - Write only; direction bit is 0
// - Mode 0: subaddress then data, acked
// - Three-wire: address byte then data byte
// - Strobe frames and selects three-wire transfer; here strobe only frames, bus_sel_3w selects
`timescale 1ns/1ps
`default_nettype none
`include "pcr_cfg.svh"
module pcr_regs
	import pcr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic i2c_scl,
	input wire logic i2c_sda_in,
	output logic i2c_sda_out,
	output logic i2c_sda_oe_n,
	input wire logic tw_sclk,
	input wire logic tw_sdata,
	input wire logic serial_latch_strobe_n,
	input wire logic slave_id_strap_low,
	input wire logic slave_id_strap_high,
	input wire logic bus_sel_3w,
	input wire logic i2c_seq_mode,
	input wire logic pwrdn,
	output logic powered_down,
	output logic [2:0] filter_res_sel,
	output logic filter_res_hiz,
	output logic [7:0] filter_res_kohm,
	output logic [1:0] osc_gain_sel,
	output logic [5:0] osc_gain_mhz_per_v,
	output logic [11:0] feedback_divider,
	output logic clk_src_ext,
	output logic second_clk_en,
	output logic [4:0] phase_first,
	output logic [4:0] phase_second,
	output logic [15:0] phase_first_cdeg,
	output logic [15:0] phase_second_cdeg,
	output logic out_steer_second
);
	// Decoding shared by both phase fields
	function automatic logic [15:0] pcr_phase_cdeg(input logic [4:0] code);
		return 16'({11'h000, code} * 16'h0465);
	endfunction : pcr_phase_cdeg

	// Resistance in kilohm, zero for the open setting
	function automatic logic [7:0] pcr_res_kohm(input logic [2:0] code);
		logic [7:0] k;
		k = 8'h00;
		case (code)
			3'h1: k = 8'h80;
			3'h2: k = 8'h20;
			3'h3: k = 8'h10;
			3'h4: k = 8'h08;
			3'h5: k = 8'h04;
			3'h6: k = 8'h02;
			3'h7: k = 8'h01;
			default: k = 8'h00;
		endcase
		return k;
	endfunction : pcr_res_kohm

	localparam int SYNC_W = 7; // Pins passing the two-flop synchroniser

	logic [SYNC_W-1:0] pins; // Raw asynchronous pins
	logic [SYNC_W-1:0] sync1_q; // First stage, read only by second
	logic [SYNC_W-1:0] sync2_q; // Second stage, safe to use
	logic scl_s, sda_s, sclk_s, sdata_s, strobe_s, strap_lo_s, strap_hi_s, sel_s;
	logic pwrdn_s;

	assign pins = {slave_id_strap_high, slave_id_strap_low, bus_sel_3w,
		serial_latch_strobe_n, tw_sdata, tw_sclk, i2c_scl};

	// Two flops on every pin from outside the clock domain except i2c_seq_mode, which is used unsynchronised
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			// Idle levels: I2C clock and strobe high, so no false edge follows reset
			sync1_q <= 7'h09;
			sync2_q <= 7'h09;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
		end
	end

	// Data line and power-down get their own pair
	logic [1:0] aux1_q;
	logic [1:0] aux2_q;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			aux1_q <= 2'h1;
			aux2_q <= 2'h1;
		end else begin
			aux1_q <= {pwrdn, i2c_sda_in};
			aux2_q <= aux1_q;
		end
	end

	assign scl_s = sync2_q[0];
	assign sclk_s = sync2_q[1];
	assign sdata_s = sync2_q[2];
	assign strobe_s = sync2_q[3];
	assign sel_s = sync2_q[4];
	assign strap_lo_s = sync2_q[5];
	assign strap_hi_s = sync2_q[6];
	assign sda_s = aux2_q[0];
	assign pwrdn_s = aux2_q[1];

	// Three-wire receiver
	pcr_wr_if tw_wr ();
	pcr_tw_rx u_tw_rx (
		.sys_clk(sys_clk),
		.reset(reset),
		.sclk_s(sclk_s),
		.sdata_s(sdata_s),
		.strobe_n_s(strobe_s),
		.wr(tw_wr)
	);

	// I2C target state
	pcr_i2c_st_e st_q;
	logic scl_p_q, sda_p_q; // Previous line samples
	logic [3:0] bit_cnt_q; // Bits of the current byte
	pcr_byte_t shift_q; // Byte being received
	pcr_byte_t sub_q; // Current subaddress
	logic ack_q; // In the acknowledge slot
	logic drv_q; // Pulling the data line low
	logic i2c_stb_q; // One-cycle write pulse
	pcr_byte_t i2c_addr_q;
	pcr_byte_t i2c_data_q;
	logic start_c, stop_c, scl_rise, scl_fall, addr_hit;
	pcr_byte_t own_addr;

	assign start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop_c = scl_s && scl_p_q && !sda_p_q && sda_s;
	assign scl_rise = scl_s && !scl_p_q;
	assign scl_fall = !scl_s && scl_p_q;
	assign own_addr = {`PCR_I2C_ADDR_HI, strap_hi_s, strap_lo_s, 1'b0};
	assign addr_hit = (shift_q == own_addr);

	// Line history for start, stop and clock edges
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// Byte sequencer: address, then subaddress and data pairs, or in mode 1 one subaddress and a data stream
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_q <= PCR_ST_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			sub_q <= 8'h00;
			ack_q <= 1'b0;
			drv_q <= 1'b0;
			i2c_stb_q <= 1'b0;
			i2c_addr_q <= 8'h00;
			i2c_data_q <= 8'h00;
		end else begin
			i2c_stb_q <= 1'b0;
			if (start_c) begin
				// Start or repeated start
				st_q <= PCR_ST_ADDR;
				bit_cnt_q <= 4'h0;
				ack_q <= 1'b0;
				drv_q <= 1'b0;
			end else if (stop_c) begin
				st_q <= PCR_ST_IDLE;
				ack_q <= 1'b0;
				drv_q <= 1'b0;
			end else if (st_q != PCR_ST_IDLE && st_q != PCR_ST_SKIP) begin
				if (scl_fall && ack_q) begin
					// Acknowledge slot over, free the line
					ack_q <= 1'b0;
					drv_q <= 1'b0;
					bit_cnt_q <= 4'h0;
				end else if (scl_rise && !ack_q && bit_cnt_q != 4'h8) begin
					shift_q <= {shift_q[6:0], sda_s};
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end else if (scl_fall && !ack_q && bit_cnt_q == 4'h8) begin
					case (st_q)
						PCR_ST_ADDR: begin
							// Foreign address or read request: stay silent
							if (addr_hit) begin
								ack_q <= 1'b1;
								drv_q <= 1'b1;
								st_q <= PCR_ST_SUB;
							end else begin
								st_q <= PCR_ST_SKIP;
							end
						end
						PCR_ST_SUB: begin
							sub_q <= shift_q;
							ack_q <= 1'b1;
							drv_q <= 1'b1;
							st_q <= PCR_ST_DATA;
						end
						PCR_ST_DATA: begin
							i2c_stb_q <= 1'b1;
							i2c_addr_q <= sub_q;
							i2c_data_q <= shift_q;
							ack_q <= 1'b1;
							drv_q <= 1'b1;
							// Mode 1 streams data with auto-increment
							if (i2c_seq_mode) begin
								sub_q <= sub_q + 8'h01;
							end else begin
								st_q <= PCR_ST_SUB;
							end
						end
						default: st_q <= PCR_ST_IDLE;
					endcase
				end
			end
		end
	end

	// Open-drain data line: low while acknowledging
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			i2c_sda_out <= 1'b0;
			i2c_sda_oe_n <= 1'b1;
		end else begin
			i2c_sda_out <= 1'b0;
			i2c_sda_oe_n <= !drv_q;
		end
	end

	// Exactly one write source, steered by the bus select pin
	logic wr_stb;
	pcr_byte_t wr_addr;
	pcr_byte_t wr_data;
	logic wr_mode1;
	assign wr_stb = sel_s ? tw_wr.wr_stb : i2c_stb_q;
	assign wr_addr = sel_s ? tw_wr.wr_addr : i2c_addr_q;
	assign wr_data = sel_s ? tw_wr.wr_data : i2c_data_q;
	assign wr_mode1 = !sel_s && i2c_seq_mode;

	// Register store; reset stands for supply power-up, power-down is ignored here
	logic [2:0] div_hi_q; // Staged divider bits 11..9
	logic par_stage_q; // Staged parity bit
	logic par_armed_q; // First of two mode 1 loads seen
	logic [11:0] div_new;
	logic par_change;
	assign div_new = {div_hi_q, wr_data, par_stage_q};
	assign par_change = par_stage_q != feedback_divider[`PCR_PAR_BIT];

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			filter_res_sel <= `PCR_RES_RST;
			osc_gain_sel <= `PCR_GAIN_RST;
			feedback_divider <= `PCR_DIV_RST;
			div_hi_q <= 3'(`PCR_DIV_RST >> 9);
			par_stage_q <= 1'b0;
			par_armed_q <= 1'b0;
			clk_src_ext <= 1'b0;
			second_clk_en <= 1'b0;
			phase_first <= `PCR_PHASE_RST;
			phase_second <= `PCR_PHASE_RST;
			out_steer_second <= 1'b0;
		end else if (wr_stb) begin
			case (wr_addr)
				`PCR_SUB_LOOP: begin
					filter_res_sel <= wr_data[`PCR_RES_LSB +: 3];
					osc_gain_sel <= wr_data[`PCR_GAIN_LSB +: 2];
				end
				`PCR_SUB_DIV_HI: begin
					div_hi_q <= wr_data[`PCR_DIVHI_LSB +: 3];
					par_stage_q <= wr_data[`PCR_PAR_BIT];
				end
				`PCR_SUB_DIV_LO: begin
					// Mode 1 parity change: first load only arms
					if (wr_mode1 && par_change && !par_armed_q) begin
						par_armed_q <= 1'b1;
					end else begin
						feedback_divider <= div_new;
						par_armed_q <= 1'b0;
					end
				end
				`PCR_SUB_PHA: begin
					phase_first <= wr_data[`PCR_PHASE_LSB +: 5];
					clk_src_ext <= wr_data[`PCR_CKSRC_BIT];
				end
				`PCR_SUB_PHB: begin
					phase_second <= wr_data[`PCR_PHASE_LSB +: 5];
					second_clk_en <= wr_data[`PCR_CK2EN_BIT];
					out_steer_second <= wr_data[`PCR_STEER_BIT];
				end
				default: ;
			endcase
		end
	end

	// Decoded views of the settings, one cycle behind the store
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			filter_res_hiz <= 1'b0;
			filter_res_kohm <= `PCR_KOHM_RST;
			osc_gain_mhz_per_v <= `PCR_MHZV_RST;
			phase_first_cdeg <= 16'h0000;
			phase_second_cdeg <= 16'h0000;
			powered_down <= 1'b0;
		end else begin
			filter_res_hiz <= (filter_res_sel == 3'h0);
			filter_res_kohm <= pcr_res_kohm(filter_res_sel);
			case (osc_gain_sel)
				2'h0: osc_gain_mhz_per_v <= 6'h0F;
				2'h1: osc_gain_mhz_per_v <= 6'h14;
				2'h2: osc_gain_mhz_per_v <= 6'h23;
				default: osc_gain_mhz_per_v <= 6'h32;
			endcase
			phase_first_cdeg <= pcr_phase_cdeg(phase_first);
			phase_second_cdeg <= pcr_phase_cdeg(phase_second);
			powered_down <= pwrdn_s;
		end
	end

	property p_defaults;
		@(posedge sys_clk) reset |=> filter_res_sel == 3'h3 && osc_gain_sel == 2'h0 &&
			feedback_divider == 12'h320 && !clk_src_ext && !second_clk_en &&
			phase_first == 5'h00 && phase_second == 5'h00 && !out_steer_second;
	endproperty
	a_defaults: assert property (p_defaults) else $error("defaults not loaded");

	property p_res_map;
		@(posedge sys_clk) disable iff (reset)
		$stable(filter_res_sel) && filter_res_sel >= 3'h2 |=>
			filter_res_kohm == (8'h40 >> ($past(filter_res_sel) - 3'h1));
	endproperty
	a_res_map: assert property (p_res_map) else $error("resistance decode wrong");

	// Gain code held over two edges, so the decode has caught up
	sequence s_gain_held;
		osc_gain_sel == 2'h2 ##1 osc_gain_sel == 2'h2;
	endsequence

	property p_gain_map;
		@(posedge sys_clk) disable iff (reset)
		s_gain_held |-> osc_gain_mhz_per_v == 6'h23;
	endproperty
	a_gain_map: assert property (p_gain_map) else $error("gain decode wrong");

	property p_phase;
		@(posedge sys_clk) disable iff (reset)
		##1 phase_second_cdeg == 16'({11'h000, $past(phase_second)} * 16'h0465);
	endproperty
	a_phase: assert property (p_phase) else $error("phase decode wrong");

	property p_pwrdn_hold;
		@(posedge sys_clk) disable iff (reset)
		pwrdn_s && !wr_stb |=> $stable(feedback_divider) && $stable(phase_first);
	endproperty
	a_pwrdn_hold: assert property (p_pwrdn_hold) else $error("power-down altered data");

	property p_addr_ack;
		@(posedge sys_clk) disable iff (reset)
		$rose(drv_q) && $past(st_q) == PCR_ST_ADDR |-> $past(shift_q) == own_addr;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("acked foreign address");

	property p_parity_twice;
		@(posedge sys_clk) disable iff (reset)
		wr_stb && wr_addr == `PCR_SUB_DIV_LO && wr_mode1 && par_change && !par_armed_q
			|=> $stable(feedback_divider) ##1 par_armed_q;
	endproperty
	a_parity_twice: assert property (p_parity_twice) else $error("parity applied on first load");

	property p_steer;
		@(posedge sys_clk) disable iff (reset)
		wr_stb && wr_addr == `PCR_SUB_PHB |=> out_steer_second == $past(wr_data[`PCR_STEER_BIT]);
	endproperty
	a_steer: assert property (p_steer) else $error("steering bit not stored");

	property p_one_source;
		@(posedge sys_clk) disable iff (reset)
		!sel_s && !i2c_stb_q |-> !wr_stb;
	endproperty
	a_one_source: assert property (p_one_source) else $error("unselected bus wrote");
endmodule : pcr_regs
`default_nettype wire

// [pcr_host.sv]
// Host controller model for the I2C and three-wire pins of the config block
`timescale 1ns/1ps
`default_nettype none
module pcr_host (
	input wire logic sys_clk,
	input wire logic sda_w,
	output logic scl,
	output logic sda_h,
	output logic tw_sclk,
	output logic tw_sdata,
	output logic strobe_n
);
	// Idle levels: I2C lines pulled high, three-wire clock stands low
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
		tw_sclk = 1'b0;
		tw_sdata = 1'b0;
		strobe_n = 1'b1;
	end
	// Steps on the falling edge keep pin changes off the sampling edge
	task step(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : step
	// Eight bits MSB first, then released SDA for the ack slot
	task i2c_byte(input logic [7:0] b, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_h = (i == 0) ? 1'b1 : b[i-1];
			step(2);
			scl = 1'b1;
			step(2);
			if (i == 0) ack = ~sda_w;
			step(2);
			scl = 1'b0;
			step(2);
		end
	endtask : i2c_byte
	// START, address, n bytes, STOP; ack_b is the AND of all byte acks
	task i2c_wr(input logic [7:0] a, input logic [31:0] bytes, input int n,
		output logic ack_a, output logic ack_b);
		logic k;
		sda_h = 1'b0;
		step(4);
		scl = 1'b0;
		step(2);
		i2c_byte(a, ack_a);
		ack_b = 1'b1;
		for (int j = 0; j < n; j++) begin
			i2c_byte(bytes[31-8*j -: 8], k);
			ack_b = ack_b & k;
		end
		sda_h = 1'b0;
		step(2);
		scl = 1'b1;
		step(4);
		sda_h = 1'b1;
		step(4);
	endtask : i2c_wr
	// Strobe-framed transfer of n bits, MSB first, clock still outside frames
	task tw_wr(input logic [16:0] w, input int n);
		strobe_n = 1'b0;
		step(4);
		for (int i = n - 1; i >= 0; i--) begin
			tw_sdata = w[i];
			step(4);
			tw_sclk = 1'b1;
			step(4);
			tw_sclk = 1'b0;
		end
		step(4);
		strobe_n = 1'b1;
		// Released line shows the inverse, not a held value
		tw_sdata = ~tw_sdata;
		step(8);
	endtask : tw_wr
endmodule : pcr_host
`default_nettype wire

// [pcr_regs_bench.sv]
// Self-checking bench for the clock config registers
`timescale 1ns/1ps
`default_nettype none
`include "pcr_cfg.svh"
module pcr_regs_bench
	import pcr_pkg::*;
	;
	// Expected register state
	typedef struct packed {
		logic [2:0] res;
		logic [1:0] gain;
		logic [11:0] div;
		logic [2:0] hi;
		logic par, arm, src, en, steer;
		logic [4:0] pa, pb;
	} pcr_tb_m_s;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic bus_sel_3w = 1'b0;
	logic i2c_seq_mode = 1'b0;
	logic pwrdn = 1'b0;
	logic slave_id_strap_low = 1'b0;
	logic slave_id_strap_high = 1'b0;
	logic i2c_scl, sda_h, sda_w, i2c_sda_out, i2c_sda_oe_n;
	logic tw_sclk, tw_sdata, serial_latch_strobe_n, powered_down;
	logic [2:0] filter_res_sel;
	logic filter_res_hiz, clk_src_ext, second_clk_en, out_steer_second;
	logic [7:0] filter_res_kohm, addr;
	logic [1:0] osc_gain_sel;
	logic [5:0] osc_gain_mhz_per_v;
	logic [11:0] feedback_divider;
	logic [4:0] phase_first, phase_second;
	logic [15:0] phase_first_cdeg, phase_second_cdeg;
	pcr_tb_m_s m;
	int error_cnt = 0;
	int checks_done = 0;
	// Open-drain SDA with pull-up
	assign sda_w = sda_h & (i2c_sda_oe_n | i2c_sda_out);
	assign addr = {5'h13, slave_id_strap_high, slave_id_strap_low, 1'b0};
	pcr_regs i_dut (.sys_clk, .reset, .i2c_scl, .i2c_sda_in(sda_w), .i2c_sda_out, .i2c_sda_oe_n,
		.tw_sclk, .tw_sdata, .serial_latch_strobe_n, .slave_id_strap_low, .slave_id_strap_high,
		.bus_sel_3w, .i2c_seq_mode, .pwrdn, .powered_down, .filter_res_sel, .filter_res_hiz,
		.filter_res_kohm, .osc_gain_sel, .osc_gain_mhz_per_v, .feedback_divider, .clk_src_ext,
		.second_clk_en, .phase_first, .phase_second, .phase_first_cdeg, .phase_second_cdeg,
		.out_steer_second);
	pcr_host i_host (.sys_clk, .sda_w, .scl(i2c_scl), .sda_h, .tw_sclk, .tw_sdata,
		.strobe_n(serial_latch_strobe_n));
	// 100 ns clock
	initial forever #50 sys_clk = ~sys_clk;
	// Watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge sys_clk);
		error_cnt++;
		summarize();
	end
	// Resistance in kilohm; code 1 breaks the halving pattern
	function automatic logic [7:0] f_kohm(input logic [2:0] c);
		return (c == 3'h1) ? 8'h80 : (8'h80 >> c);
	endfunction : f_kohm
	// Gain in MHz/V
	function automatic logic [5:0] f_mhz(input logic [1:0] c);
		case (c)
			2'h0: return 6'h0F;
			2'h1: return 6'h14;
			2'h2: return 6'h23;
			default: return 6'h32;
		endcase
	endfunction : f_mhz
	task cmp(input logic [15:0] exp, input logic [15:0] act);
		checks_done++;
		if (act !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t exp=%h act=%h", $time, exp, act);
		end
	endtask : cmp
	// Acknowledge pattern of one I2C transfer: address ack, then all data acks
	task cmp_ack(input logic [1:0] exp, input logic [1:0] act);
		checks_done++;
		if (act !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t ack exp=%h act=%h", $time, exp, act);
		end
	endtask : cmp_ack
	task m_reset;
		m = '0;
		m.res = 3'h3;
		m.div = 12'h320;
		m.hi = 3'h1;
	endtask : m_reset
	// Expected effect of one register write
	task model(input pcr_byte_t sub, input pcr_byte_t d);
		case (sub)
			`PCR_SUB_LOOP: {m.gain, m.res} = d[4:0];
			`PCR_SUB_DIV_HI: {m.hi, m.par} = d[3:0];
			`PCR_SUB_DIV_LO: begin
				// First parity-change load in I2C mode 1 only arms
				if (!bus_sel_3w && i2c_seq_mode && m.par != m.div[0] && !m.arm) m.arm = 1'b1;
				else begin
					m.div = {m.hi, d, m.par};
					m.arm = 1'b0;
				end
			end
			`PCR_SUB_PHA: {m.src, m.pa} = d[5:0];
			`PCR_SUB_PHB: {m.steer, m.en, m.pb} = d[6:0];
			default: ;
		endcase
	endtask : model
	task check_all;
		cmp(16'(m.res), 16'(filter_res_sel));
		cmp(16'(m.res == 3'h0), 16'(filter_res_hiz));
		if (m.res != 3'h0) cmp(16'(f_kohm(m.res)), 16'(filter_res_kohm));
		cmp(16'(m.gain), 16'(osc_gain_sel));
		cmp(16'(f_mhz(m.gain)), 16'(osc_gain_mhz_per_v));
		cmp(16'(m.div), 16'(feedback_divider));
		cmp(16'(m.src), 16'(clk_src_ext));
		cmp(16'(m.en), 16'(second_clk_en));
		cmp(16'({m.pa, m.pb}), 16'({phase_first, phase_second}));
		cmp(16'(m.pa) * 16'h0465, phase_first_cdeg);
		cmp(16'(m.pb) * 16'h0465, phase_second_cdeg);
		cmp(16'(m.steer), 16'(out_steer_second));
	endtask : check_all
	task settle_check;
		repeat (12) @(negedge sys_clk);
		check_all();
	endtask : settle_check
	task wait_n(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : wait_n
	// One register write on the selected bus
	task wr(input pcr_byte_t sub, input pcr_byte_t d);
		logic aa, ab;
		if (bus_sel_3w) i_host.tw_wr({1'b0, sub, d}, 16);
		else begin
			i_host.i2c_wr(addr, {sub, d, 16'h0000}, 2, aa, ab);
			cmp_ack(2'h3, {aa, ab});
		end
		model(sub, d);
		settle_check();
	endtask : wr
	task done_test(input string s);
		$display("test %s done, errors %0d", s, error_cnt);
	endtask : done_test
	task summarize;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize
	initial begin
		logic aa, ab;
		void'($urandom(70312));
		@(negedge sys_clk);
		{slave_id_strap_high, slave_id_strap_low} = 2'($urandom);
		wait_n(20);
		reset = 1'b0;
		m_reset();
		wait_n(6);
		check_all();
		done_test("defaults");
		// Every resistance, gain and phase boundary, alternating buses
		for (int k = 0; k < 8; k++) begin
			bus_sel_3w = k[0];
			wait_n(6);
			wr(`PCR_SUB_LOOP, 8'(k * 9));
			wr(`PCR_SUB_PHA, {2'h0, k[1], (k == 7) ? 5'h1F : 5'(k * 3)});
			wr(`PCR_SUB_PHB, {1'b0, k[2], k[1], 5'h1F - 5'(k)});
		end
		// High bits and parity first, then low bits, odd then even
		for (int k = 0; k < 2; k++) begin
			bus_sel_3w = k[0];
			wait_n(6);
			wr(`PCR_SUB_DIV_HI, 8'h0F - 8'(k));
			wr(`PCR_SUB_DIV_LO, 8'hFF);
		end
		done_test("codes");
		// Mode 1 auto-increment with a parity change: second load applies
		bus_sel_3w = 1'b0;
		i2c_seq_mode = 1'b1;
		wait_n(6);
		i_host.i2c_wr(addr, {`PCR_SUB_DIV_HI, 8'h03, 8'h55, 8'h00}, 3, aa, ab);
		cmp_ack(2'h3, {aa, ab});
		model(`PCR_SUB_DIV_HI, 8'h03);
		model(`PCR_SUB_DIV_LO, 8'h55);
		settle_check();
		i_host.i2c_wr(addr, {`PCR_SUB_DIV_LO, 8'h55, 16'h0000}, 2, aa, ab);
		cmp_ack(2'h3, {aa, ab});
		model(`PCR_SUB_DIV_LO, 8'h55);
		settle_check();
		i2c_seq_mode = 1'b0;
		// Mode 0: two pairs after one address
		i_host.i2c_wr(addr, {`PCR_SUB_LOOP, 8'h17, `PCR_SUB_PHB, 8'h45}, 4, aa, ab);
		cmp_ack(2'h3, {aa, ab});
		model(`PCR_SUB_LOOP, 8'h17);
		model(`PCR_SUB_PHB, 8'h45);
		settle_check();
		done_test("sequences");
		// Read bit or wrong strap bit: no ack, no effect
		for (int k = 0; k < 3; k++) begin
			i_host.i2c_wr(addr ^ (8'h01 << k), {`PCR_SUB_LOOP, 8'h01, 16'h0000}, 2, aa, ab);
			cmp_ack(2'h0, {aa, ab});
			settle_check();
		end
		wr(8'h0F, 8'hAA);
		done_test("refusals");
		// Unselected bus and wrong frame lengths are dropped
		bus_sel_3w = 1'b1;
		wait_n(6);
		i_host.i2c_wr(addr, {`PCR_SUB_LOOP, 8'h02, 16'h0000}, 2, aa, ab);
		settle_check();
		i_host.tw_wr({2'h0, `PCR_SUB_LOOP, 7'h05}, 15);
		i_host.tw_wr({`PCR_SUB_LOOP, 8'h05, 1'b1}, 17);
		settle_check();
		bus_sel_3w = 1'b0;
		wait_n(6);
		i_host.tw_wr({1'b0, `PCR_SUB_LOOP, 8'h02}, 16);
		settle_check();
		done_test("bus select");
		// Power-down in and out keeps contents
		pwrdn = 1'b1;
		wait_n(6);
		cmp(16'(powered_down), 16'h0001);
		check_all();
		pwrdn = 1'b0;
		wait_n(6);
		cmp(16'(powered_down), 16'h0000);
		check_all();
		done_test("power-down");
		for (int k = 0; k < 30; k++) begin
			bus_sel_3w = 1'($urandom);
			wait_n(6);
			wr(8'h0A + 8'($urandom_range(4)), 8'($urandom));
		end
		done_test("random");
		// Second reset in mid-run
		reset = 1'b1;
		wait_n(4);
		reset = 1'b0;
		m_reset();
		wait_n(6);
		check_all();
		done_test("reset");
		summarize();
	end
endmodule : pcr_regs_bench
`default_nettype wire
